/* design/twmt_pkg.sv */
/*
 * Constants, register layout and state codes of the two-wire master
 * transmitter. Assumes a 100 MHz system clock and an APB register bus.
 */
package twmt_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DATA = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFS_IRQ_EN = 8'h10;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h14;

    typedef struct packed {
        logic flag;
        logic ack_enable;
        logic start_request;
        logic stop_request;
        logic write_collision;
        logic enable;
        logic rsv;
        logic irq_enable;
    } twmt_ctrl_s;

    typedef struct packed {
        logic [4:0] rsv;
        logic arb_lost;
        logic wcol;
        logic flag_set;
    } twmt_irq_s;

    localparam twmt_ctrl_s CTRL_RST = 8'h00;
    localparam twmt_irq_s IRQ_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'hFF;
    localparam logic [1:0] PRESC_RST = 2'h0;

    // Status codes, prescaler bits zero
    localparam logic [7:0] CODE_START = 8'h08;
    localparam logic [7:0] CODE_RSTART = 8'h10;
    localparam logic [7:0] CODE_AW_ACK = 8'h18;
    localparam logic [7:0] CODE_AW_NACK = 8'h20;
    localparam logic [7:0] CODE_DATA_ACK = 8'h28;
    localparam logic [7:0] CODE_DATA_NACK = 8'h30;
    localparam logic [7:0] CODE_ARB_LOST = 8'h38;
    localparam logic [7:0] CODE_AR_ACK = 8'h40;
    localparam logic [7:0] CODE_AR_NACK = 8'h48;
    localparam logic [7:0] CODE_RX_ACK = 8'h50;
    localparam logic [7:0] CODE_RX_NACK = 8'h58;
    localparam logic [7:0] CODE_IDLE = 8'hF8;

    // Bit timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_HALF_NS = 40;
    localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [7:0] TMR_RST = 8'h00;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_WAIT_FREE = 4'b0001,
        ST_START_HI = 4'b0010,
        ST_START_LO = 4'b0011,
        ST_BIT_LO = 4'b0100,
        ST_BIT_HI = 4'b0101,
        ST_HOLD = 4'b0110,
        ST_STOP_LO = 4'b0111,
        ST_STOP_HI = 4'b1000,
        ST_STOP_END = 4'b1001,
        ST_RS_LO = 4'b1010
    } twmt_state_e;

endpackage

/* design/twmt_top.sv */
/*
 * Two-wire master transmitter (with master receive path) behind an APB
 * register slave, with sticky interrupt status. Assumes open-drain
 * SCL/SDA resolved outside, and pin inputs asynchronous to sys_clk.
 */
module twmt_top #(
    parameter int SCL_HALF = twmt_pkg::SCL_HALF_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Two-wire pins
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Interrupt
    output logic irq
);
    import twmt_pkg::*;

    localparam logic [7:0] HALF_M1 = 8'(SCL_HALF - 1);

    twmt_state_e state_ff;
    twmt_ctrl_s ctrl_ff;
    twmt_ctrl_s wr_ctrl_val;
    twmt_irq_s irq_stat_ff;
    twmt_irq_s irq_en_ff;
    twmt_irq_s irq_set;
    logic [7:0] data_ff;
    logic [7:0] code_ff;
    logic [7:0] shift_ff;
    logic [7:0] tmr_ff;
    logic [3:0] bit_ff;
    logic [1:0] presc_ff;
    logic scl_m_ff, scl_s_ff, sda_m_ff, sda_s_ff, sda_d_ff;
    logic bus_busy_ff;
    logic scl_oe_n_ff, sda_oe_n_ff, scl_out_ff, sda_out_ff;
    logic addr_ph_ff, rx_mode_ff, rep_ff;
    logic ev_flag_ff, ev_arb_ff, stop_done_ff, rx_load_ff;
    logic prdy_ff, pslverr_ff, irq_ff;
    logic [31:0] prdata_ff;
    logic [31:0] rd_data;
    logic rd_hit;
    logic apb_wr, wr_ctrl, wr_data, wr_stat, wr_ien, wr_iclr, wcol_evt;
    logic tmr_done, hold_go, tx_ph, out_bit, arb_loss;

    // Register access, one word per register
    assign apb_wr = psel && penable && prdy_ff && pwrite;
    assign wr_ctrl = apb_wr && (paddr == OFS_CTRL);
    assign wr_data = apb_wr && (paddr == OFS_DATA);
    assign wr_stat = apb_wr && (paddr == OFS_STAT);
    assign wr_ien = apb_wr && (paddr == OFS_IRQ_EN);
    assign wr_iclr = apb_wr && (paddr == OFS_IRQ_CLR);
    assign wr_ctrl_val = twmt_ctrl_s'(pwdata[7:0]);
    assign wcol_evt = wr_data && !ctrl_ff.flag;

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        if (paddr == OFS_CTRL) begin
            rd_data[7:0] = ctrl_ff;
        end else if (paddr == OFS_DATA) begin
            rd_data[7:0] = data_ff;
        end else if (paddr == OFS_STAT) begin
            rd_data[7:0] = {code_ff[7:3], 1'b0, presc_ff};
        end else if (paddr == OFS_IRQ_STAT) begin
            rd_data[7:0] = irq_stat_ff;
        end else if (paddr == OFS_IRQ_EN) begin
            rd_data[7:0] = irq_en_ff;
        end else if (paddr == OFS_IRQ_CLR) begin
            rd_data = 32'h0000_0000;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Zero-wait slave: ready in every access phase
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            prdy_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            prdy_ff <= psel && !penable;
            pslverr_ff <= psel && !penable && !rd_hit;
            // Writes return zero so an unmapped write never shows stale data
            if (psel && !penable) begin
                prdata_ff <= pwrite ? 32'h0000_0000 : rd_data;
            end
        end
    end

    // Control register; hardware set wins over software clear
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ctrl_ff <= CTRL_RST;
        end else begin
            if (stop_done_ff) begin
                ctrl_ff.stop_request <= 1'b0;
            end
            if (wr_ctrl) begin
                ctrl_ff.ack_enable <= wr_ctrl_val.ack_enable;
                ctrl_ff.start_request <= wr_ctrl_val.start_request;
                ctrl_ff.stop_request <= wr_ctrl_val.stop_request;
                ctrl_ff.enable <= wr_ctrl_val.enable;
                ctrl_ff.irq_enable <= wr_ctrl_val.irq_enable;
                if (wr_ctrl_val.flag) begin
                    ctrl_ff.flag <= 1'b0;
                end
            end
            if (wcol_evt) begin
                ctrl_ff.write_collision <= 1'b1;
            end else if (wr_data) begin
                ctrl_ff.write_collision <= 1'b0;
            end
            if (ev_flag_ff) begin
                ctrl_ff.flag <= 1'b1;
            end
        end
    end

    // Data and prescaler bits
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            data_ff <= DATA_RST;
            presc_ff <= PRESC_RST;
        end else begin
            if (wr_data && ctrl_ff.flag) begin
                data_ff <= pwdata[7:0];
            end else if (rx_load_ff) begin
                data_ff <= shift_ff;
            end
            if (wr_stat) begin
                presc_ff <= pwdata[1:0];
            end
        end
    end

    // Interrupt status, enable, clear
    assign irq_set = {5'h00, ev_arb_ff, wcol_evt, ev_flag_ff};

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            irq_stat_ff <= IRQ_RST;
            irq_en_ff <= IRQ_RST;
            irq_ff <= 1'b0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~(wr_iclr ? twmt_irq_s'(pwdata[7:0]) : IRQ_RST))
                           | irq_set;
            if (wr_ien) begin
                irq_en_ff <= twmt_irq_s'(pwdata[7:0]);
            end
            irq_ff <= |(irq_stat_ff & irq_en_ff);
        end
    end

    // Pin synchronisers and bus-free detection
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            scl_m_ff <= 1'b1;
            scl_s_ff <= 1'b1;
            sda_m_ff <= 1'b1;
            sda_s_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            bus_busy_ff <= 1'b0;
        end else begin
            scl_m_ff <= scl_in;
            scl_s_ff <= scl_m_ff;
            sda_m_ff <= sda_in;
            sda_s_ff <= sda_m_ff;
            sda_d_ff <= sda_s_ff;
            if (scl_s_ff && sda_d_ff && !sda_s_ff) begin
                bus_busy_ff <= 1'b1;
            end else if (scl_s_ff && !sda_d_ff && sda_s_ff) begin
                bus_busy_ff <= 1'b0;
            end
        end
    end

    // Bit engine
    assign tmr_done = (tmr_ff == HALF_M1);
    // Flag raised this cycle is not yet visible in ctrl_ff
    assign hold_go = !ctrl_ff.flag && !ev_flag_ff;
    assign tx_ph = addr_ph_ff || !rx_mode_ff;
    // Released line sends one, pulled line sends zero
    assign out_bit = (bit_ff != BIT_LAST) ? (tx_ph ? shift_ff[7] : 1'b1)
                                          : (tx_ph ? 1'b1 : !ctrl_ff.ack_enable);
    assign arb_loss = tx_ph && (bit_ff != BIT_LAST) && shift_ff[7] && !sda_s_ff;

    always_ff @(posedge sys_clk) begin
        ev_flag_ff <= 1'b0;
        ev_arb_ff <= 1'b0;
        stop_done_ff <= 1'b0;
        rx_load_ff <= 1'b0;
        if (!rstn) begin
            state_ff <= ST_IDLE;
            tmr_ff <= TMR_RST;
            bit_ff <= 4'h0;
            shift_ff <= 8'h00;
            code_ff <= CODE_IDLE;
            scl_oe_n_ff <= 1'b1;
            sda_oe_n_ff <= 1'b1;
            addr_ph_ff <= 1'b0;
            rx_mode_ff <= 1'b0;
            rep_ff <= 1'b0;
        end else if (!ctrl_ff.enable) begin
            state_ff <= ST_IDLE;
            tmr_ff <= TMR_RST;
            scl_oe_n_ff <= 1'b1;
            sda_oe_n_ff <= 1'b1;
        end else begin
            tmr_ff <= tmr_ff + 8'h01;
            case (state_ff)
                ST_IDLE: begin
                    tmr_ff <= TMR_RST;
                    if (ctrl_ff.start_request && hold_go) begin
                        state_ff <= ST_WAIT_FREE;
                    end
                end
                ST_WAIT_FREE: begin
                    tmr_ff <= TMR_RST;
                    if (!bus_busy_ff) begin
                        rep_ff <= 1'b0;
                        state_ff <= ST_START_HI;
                    end
                end
                ST_START_HI: begin
                    if (!scl_s_ff) begin
                        tmr_ff <= TMR_RST;
                    end else if (tmr_done) begin
                        tmr_ff <= TMR_RST;
                        sda_oe_n_ff <= 1'b0;
                        state_ff <= ST_START_LO;
                    end
                end
                ST_START_LO: begin
                    if (tmr_done) begin
                        tmr_ff <= TMR_RST;
                        scl_oe_n_ff <= 1'b0;
                        code_ff <= rep_ff ? CODE_RSTART : CODE_START;
                        ev_flag_ff <= 1'b1;
                        addr_ph_ff <= 1'b1;
                        state_ff <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    tmr_ff <= TMR_RST;
                    if (hold_go) begin
                        if (ctrl_ff.stop_request) begin
                            sda_oe_n_ff <= 1'b0;
                            state_ff <= ST_STOP_LO;
                        end else if (ctrl_ff.start_request) begin
                            sda_oe_n_ff <= 1'b1;
                            state_ff <= ST_RS_LO;
                        end else begin
                            shift_ff <= data_ff;
                            bit_ff <= 4'h0;
                            state_ff <= ST_BIT_LO;
                        end
                    end
                end
                ST_BIT_LO: begin
                    if (tmr_ff == TMR_RST) begin
                        sda_oe_n_ff <= out_bit;
                    end
                    if (tmr_done) begin
                        tmr_ff <= TMR_RST;
                        scl_oe_n_ff <= 1'b1;
                        state_ff <= ST_BIT_HI;
                    end
                end
                ST_BIT_HI: begin
                    // Slave may stretch the clock low
                    if (!scl_s_ff) begin
                        tmr_ff <= TMR_RST;
                    end else if (tmr_done) begin
                        tmr_ff <= TMR_RST;
                        if (arb_loss) begin
                            code_ff <= CODE_ARB_LOST;
                            ev_flag_ff <= 1'b1;
                            ev_arb_ff <= 1'b1;
                            sda_oe_n_ff <= 1'b1;
                            state_ff <= ST_IDLE;
                        end else if (bit_ff == BIT_LAST) begin
                            scl_oe_n_ff <= 1'b0;
                            sda_oe_n_ff <= 1'b1;
                            ev_flag_ff <= 1'b1;
                            state_ff <= ST_HOLD;
                            if (addr_ph_ff) begin
                                addr_ph_ff <= 1'b0;
                                rx_mode_ff <= shift_ff[0];
                                if (shift_ff[0]) begin
                                    code_ff <= sda_s_ff ? CODE_AR_NACK : CODE_AR_ACK;
                                end else begin
                                    code_ff <= sda_s_ff ? CODE_AW_NACK : CODE_AW_ACK;
                                end
                            end else if (rx_mode_ff) begin
                                rx_load_ff <= 1'b1;
                                code_ff <= sda_s_ff ? CODE_RX_NACK : CODE_RX_ACK;
                            end else begin
                                code_ff <= sda_s_ff ? CODE_DATA_NACK : CODE_DATA_ACK;
                            end
                        end else begin
                            shift_ff <= {shift_ff[6:0], sda_s_ff};
                            bit_ff <= bit_ff + 4'h1;
                            scl_oe_n_ff <= 1'b0;
                            state_ff <= ST_BIT_LO;
                        end
                    end
                end
                ST_STOP_LO: begin
                    if (tmr_done) begin
                        tmr_ff <= TMR_RST;
                        scl_oe_n_ff <= 1'b1;
                        state_ff <= ST_STOP_HI;
                    end
                end
                ST_STOP_HI: begin
                    if (!scl_s_ff) begin
                        tmr_ff <= TMR_RST;
                    end else if (tmr_done) begin
                        tmr_ff <= TMR_RST;
                        sda_oe_n_ff <= 1'b1;
                        state_ff <= ST_STOP_END;
                    end
                end
                ST_STOP_END: begin
                    if (tmr_done) begin
                        tmr_ff <= TMR_RST;
                        stop_done_ff <= 1'b1;
                        code_ff <= CODE_IDLE;
                        rx_mode_ff <= 1'b0;
                        state_ff <= ctrl_ff.start_request ? ST_WAIT_FREE : ST_IDLE;
                    end
                end
                ST_RS_LO: begin
                    if (tmr_done) begin
                        tmr_ff <= TMR_RST;
                        scl_oe_n_ff <= 1'b1;
                        rep_ff <= 1'b1;
                        state_ff <= ST_START_HI;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Pin output levels: open drain only ever pulls low
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            scl_out_ff <= 1'b0;
            sda_out_ff <= 1'b0;
        end else begin
            scl_out_ff <= 1'b0;
            sda_out_ff <= 1'b0;
        end
    end

    assign prdata = prdata_ff;
    assign pready = prdy_ff;
    assign pslverr = pslverr_ff;
    assign scl_out = scl_out_ff;
    assign scl_oe_n = scl_oe_n_ff;
    assign sda_out = sda_out_ff;
    assign sda_oe_n = sda_oe_n_ff;
    assign irq = irq_ff;

endmodule

/* sim/twmt_properties.sv */
/* Port checker of the two-wire master transmitter.
   Bound to twmt_top; sees its ports only. */
module twmt_properties
    import twmt_pkg::*;
#(
    parameter int SCL_HALF = 4
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and interrupt
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe_n,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic irq
);
    logic [7:0] hi_cnt_ff;
    logic [7:0] lo_cnt_ff;

    // Saturating, so long idle or stall stretches never wrap
    always_ff @(posedge sys_clk) begin
        if (!rstn || !scl_oe_n) begin
            hi_cnt_ff <= 8'h00;
        end else if (hi_cnt_ff != 8'hFF) begin
            hi_cnt_ff <= hi_cnt_ff + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn || scl_oe_n) begin
            lo_cnt_ff <= 8'h00;
        end else if (lo_cnt_ff != 8'hFF) begin
            lo_cnt_ff <= lo_cnt_ff + 8'h01;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_mask_off;
        psel && penable && pready && pwrite && paddr == OFS_IRQ_EN && pwdata[7:0] == 8'h00;
    endsequence

    property p_ready_pulse;
        s_setup |=> pready ##1 !pready;
    endproperty
    property p_no_ready;
        !psel |=> !pready;
    endproperty
    property p_bad_addr;
        s_setup and (paddr > OFS_IRQ_CLR) |=> pslverr && prdata == 32'h00000000;
    endproperty
    property p_good_addr;
        s_setup and (paddr[1:0] == 2'h0 && paddr <= OFS_IRQ_CLR) |=> !pslverr;
    endproperty
    property p_upper_zero;
        pready |-> prdata[31:8] == 24'h000000;
    endproperty
    property p_reset_out;
        $rose(rstn) |-> scl_oe_n && sda_oe_n && !irq && !pready;
    endproperty
    property p_irq_mask;
        s_mask_off |=> ##1 !irq;
    endproperty
    property p_scl_high;
        $fell(scl_oe_n) |-> int'(hi_cnt_ff) >= SCL_HALF;
    endproperty
    property p_scl_low;
        $rose(scl_oe_n) |-> int'(lo_cnt_ff) >= SCL_HALF;
    endproperty

    a_ready_pulse: assert property (p_ready_pulse) else $error("pready not a pulse");
    a_no_ready: assert property (p_no_ready) else $error("pready without select");
    a_bad_addr: assert property (p_bad_addr) else $error("unmapped not refused");
    a_good_addr: assert property (p_good_addr) else $error("mapped refused");
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    a_reset_out: assert property (p_reset_out) else $error("outputs not at reset");
    a_irq_mask: assert property (p_irq_mask) else $error("irq despite mask");
    a_scl_high: assert property (p_scl_high) else $error("clock high too short");
    a_scl_low: assert property (p_scl_low) else $error("clock low too short");
endmodule

bind twmt_top twmt_properties #(.SCL_HALF(SCL_HALF)) i_props (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq));

/* sim/twmt_slave.sv */
/* Slave receiver on the two-wire bus.
   Assumes pulled-up wires resolved by the bench. */
module twmt_slave (
    // Clock
    input wire logic sys_clk,
    // Wires and behaviour
    input wire logic scl,
    input wire logic sda,
    input wire logic nack,
    input wire logic [7:0] stretch,
    // Pulls and capture
    output logic scl_pull,
    output logic sda_pull,
    output logic [7:0] rx_byte,
    output logic [7:0] rx_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic scl_q = 1'h1;
    logic sda_q = 1'h1;
    logic [3:0] bits = 4'h0;
    logic [7:0] shreg = 8'h00;
    logic [7:0] hold = 8'h00;

    initial begin
        scl_pull = 1'h0;
        sda_pull = 1'h0;
        rx_byte = 8'h00;
        rx_cnt = 8'h00;
    end

    always @(posedge sys_clk) begin
        scl_q <= scl;
        sda_q <= sda;
        if (hold != 8'h00) begin
            hold <= hold - 8'h01;
        end else begin
            scl_pull <= 1'h0;
        end
        if (scl && scl_q && sda_q && !sda) begin
            bits <= 4'h0;
        end else if (scl && !scl_q) begin
            shreg <= (bits < 4'h8) ? {shreg[6:0], sda} : shreg;
            bits <= bits + 4'h1;
        end else if (!scl && scl_q) begin
            // Slow slave: hold the clock low after each fall
            if (stretch != 8'h00) begin
                scl_pull <= 1'h1;
                hold <= stretch;
            end
            if (bits == 4'h8) begin
                sda_pull <= !nack;
            end
            if (bits == 4'h9) begin
                sda_pull <= 1'h0;
                bits <= 4'h0;
                rx_byte <= shreg;
                rx_cnt <= rx_cnt + 8'h01;
            end
        end
    end
endmodule

/* sim/twmt_top_tb.sv */
/* Self-checking bench of the two-wire master transmitter.
   Assumes the slave model and port checker compiled before it. */
module twmt_top_tb import twmt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, irq, er;
    logic scl_out, scl_oe_n, sda_out, sda_oe_n, s_scl, s_sda, x_sda, nack;
    logic [7:0] paddr, stretch, rx_byte, rx_cnt;
    logic [31:0] pwdata, prdata, rd;
    wire scl = (scl_oe_n | scl_out) & !s_scl;
    wire sda = (sda_oe_n | sda_out) & !s_sda & !x_sda;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    twmt_top #(.SCL_HALF(4)) i_dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out),
        .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq));
    twmt_slave i_slave (.sys_clk(sys_clk), .scl(scl), .sda(sda), .nack(nack),
        .stretch(stretch), .scl_pull(s_scl), .sda_pull(s_sda), .rx_byte(rx_byte),
        .rx_cnt(rx_cnt));

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp({31'h0, got}, {31'h0, exp});
    endtask

    // No wait-state limit here: only the cycle ceiling ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge sys_clk);
        penable <= 1'h1;
        do @(posedge sys_clk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge sys_clk);
    endtask

    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        apb(1'h0, a, 8'h00);
        cmp(rd, {24'h000000, e});
    endtask

    task automatic poll(input logic [7:0] m, input logic [7:0] v);
        do apb(1'h0, OFS_CTRL, 8'h00); while ((rd[7:0] & m) !== v);
    endtask

    task automatic step(input logic [7:0] c, input logic [7:0] code);
        apb(1'h1, OFS_CTRL, c);
        poll(8'h80, 8'h80);
        apb(1'h0, OFS_STAT, 8'h00);
        cmp(rd & 32'hF8, {24'h000000, code});
    endtask

    task automatic send(input logic [7:0] d, input logic [7:0] code);
        apb(1'h1, OFS_DATA, d);
        step(8'h84, code);
    endtask

    task automatic t_reset();
        chk(OFS_CTRL, 8'h00);
        chk(OFS_DATA, 8'hFF);
        chk(OFS_STAT, 8'hF8);
        chk(OFS_IRQ_STAT, 8'h00);
        chk(OFS_IRQ_EN, 8'h00);
        apb(1'h0, 8'h40, 8'h00);
        cmp({rd[30:0], er}, 32'h00000001);
        $display("reset test done");
    endtask

    task automatic t_frame();
        apb(1'h1, OFS_IRQ_EN, 8'h01);
        apb(1'h1, OFS_STAT, 8'h03);
        step(8'hA4, CODE_START);
        cmp_bit(irq, 1'h1);
        apb(1'h1, OFS_CTRL, 8'h04);
        chk(OFS_CTRL, 8'h84);
        repeat (60) @(posedge sys_clk);
        cmp_bit(scl, 1'h0);
        send(8'hA6, CODE_AW_ACK);
        cmp({24'h000000, rx_byte}, 32'h000000A6);
        apb(1'h1, OFS_IRQ_CLR, 8'h01);
        repeat (2) @(posedge sys_clk);
        cmp_bit(irq, 1'h0);
        stretch <= 8'h14;
        send(8'h5A, CODE_DATA_ACK);
        stretch <= 8'h00;
        cmp({24'h000000, rx_byte}, 32'h0000005A);
        cmp_bit(irq, 1'h1);
        step(8'hA4, CODE_RSTART);
        nack <= 1'h1;
        send(8'hA6, CODE_AW_NACK);
        send(8'hC3, CODE_DATA_NACK);
        nack <= 1'h0;
        apb(1'h1, OFS_CTRL, 8'h94);
        poll(8'h10, 8'h00);
        chk(OFS_STAT, 8'hFB);
        cmp_bit(sda & scl, 1'h1);
        apb(1'h1, OFS_IRQ_EN, 8'h00);
        repeat (2) @(posedge sys_clk);
        cmp_bit(irq, 1'h0);
        $display("frame test done");
    endtask

    task automatic t_wcol();
        apb(1'h1, OFS_DATA, 8'h11);
        chk(OFS_DATA, 8'hC3);
        apb(1'h0, OFS_CTRL, 8'h00);
        cmp(rd & 32'h08, 32'h00000008);
        chk(OFS_IRQ_STAT, 8'h03);
        $display("collision test done");
    endtask

    task automatic t_busy();
        x_sda <= 1'h1;
        repeat (10) @(posedge sys_clk);
        apb(1'h1, OFS_CTRL, 8'hA4);
        repeat (200) @(posedge sys_clk);
        cmp_bit(sda_oe_n & scl_oe_n, 1'h1);
        apb(1'h0, OFS_CTRL, 8'h00);
        cmp(rd & 32'h80, 32'h00000000);
        x_sda <= 1'h0;
        poll(8'h80, 8'h80);
        apb(1'h0, OFS_STAT, 8'h00);
        cmp(rd & 32'hF8, {24'h000000, CODE_START});
        x_sda <= 1'h1;
        send(8'hA7, CODE_ARB_LOST);
        x_sda <= 1'h0;
        chk(OFS_IRQ_STAT, 8'h07);
        step(8'hA4, CODE_START);
        send(8'hA7, CODE_AR_ACK);
        step(8'hC4, CODE_RX_ACK);
        chk(OFS_DATA, 8'hFF);
        apb(1'h1, OFS_CTRL, 8'h80);
        repeat (4) @(posedge sys_clk);
        cmp_bit(scl & sda, 1'h1);
        $display("busy bus test done");
    endtask

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        rstn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        x_sda = 1'h0;
        nack = 1'h0;
        stretch = 8'h00;
        repeat (8) @(posedge sys_clk);
        rstn <= 1'h1;
        @(posedge sys_clk);
        t_reset();
        t_frame();
        t_wcol();
        t_busy();
        end_of_test();
    end

    // Ceiling well above the fewer than two thousand cycles the tests need
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            end_of_test();
        end
    end
endmodule
